// File: include/owod_cfg.svh
`ifndef OWOD_CFG_SVH
`define OWOD_CFG_SVH
// Register offsets on the plain register port.
`define OWOD_ADDR_W         4
`define OWOD_OFS_STORE_LO   4'h0
`define OWOD_OFS_STORE_HI   4'h1
`define OWOD_OFS_CTRL       4'h2
`define OWOD_OFS_STATUS     4'h3
`define OWOD_OFS_ACTIVE     4'h4
// Option word field positions.
`define OWOD_LOCK_MSB       31
`define OWOD_LOCK_LSB       16
`define OWOD_PRELOAD_BIT    15
`define OWOD_SIZE_MSB       11
`define OWOD_SIZE_LSB       8
`define OWOD_PART_MSB       7
`define OWOD_PART_LSB       4
// Codes.
`define OWOD_LOCK_CODE      16'h33cc
`define OWOD_SIZE_2K        4'h4
`define OWOD_SIZE_ZERO      4'hf
`define OWOD_PART_32_0      4'h1
`define OWOD_PART_8_24      4'h6
`define OWOD_PART_0_32      4'h9
`define OWOD_PART_16_16     4'hb
`define OWOD_PART_24_8      4'hc
`define OWOD_PART_NONE      4'hf
// The stored entry resets to a zero low half under its complement.
`define OWOD_STORE_RESET    64'hffff_ffff_0000_0000
// Control bits.
`define OWOD_CTRL_RELOAD    0
`define OWOD_CTRL_ERASE_ACK 1
// Status bits.
`define OWOD_ST_ERR         0
`define OWOD_ST_LOCKED      1
`define OWOD_ST_ILLEGAL     2
`define OWOD_ST_ERASE       3
`define OWOD_ST_PRELOAD     4
`endif

// File: include/owod_pkg.sv
package owod_pkg;
  typedef struct packed {
    logic [15:0] lock;
    logic        preload;
    logic [2:0]  unused;
    logic [3:0]  size;
    logic [3:0]  part;
    logic [3:0]  low;
  } owod_word_type;
  typedef struct packed {
    logic [12:0] size_bytes;
    logic [5:0]  data_kb;
    logic [5:0]  backup_kb;
    logic        valid;
  } owod_layout_type;
  typedef enum logic [1:0] {
    OWOD_IDLE   = 2'b00,
    OWOD_RELOAD = 2'b01,
    OWOD_ERASE  = 2'b10
  } owod_state_type;
endpackage

// File: src/owod_decoder.sv
// Overview of operation
// - A lock field equal to 0x33cc refuses every later write to the word.
// - Any other lock field value leaves the word writable.
// - Bit 15 set asks the flash reset sequence to preload shared RAM.
// - Size code 0100 means 2048 bytes, 1111 zero bytes, others reserved.
// - Partition 0001/0110/1001/1011/1100 give 32/0,8/24,0/32,16/16,24/8 KB.
// - Partition code 1111 is the default and means no valid partition.
// - A reload whose high half is not the low half complemented errors.
// - Illegal size/partition changes are ignored and flag an error.
// - A change of size or partition erases the whole extended flash (here asked for on a reload request only, never by the boot load).
// - A stored change takes effect only on reset or on a reload request.
`include "owod_cfg.svh"
`default_nettype none
module owod_decoder
  import owod_pkg::*;
(
  input  wire logic                    clk_in,
  input  wire logic                    arst_n_in,
  input  wire logic                    clk_en_in,
  input  wire logic [`OWOD_ADDR_W-1:0] addr_in,
  input  wire logic [31:0]             wdata_in,
  input  wire logic                    wr_in,
  input  wire logic                    rd_in,
  output logic      [31:0]             rdata_out,
  output logic                         preload_out,
  output owod_layout_type              layout_out,
  output logic                         erase_req_out,
  output logic                         error_out
);

  logic [63:0]     store;
  owod_word_type   active;
  owod_layout_type layout;
  owod_state_type  state;
  logic            err;
  logic            illegal;
  logic            erase_pend;
  logic            boot_load;
  logic            locked;
  owod_word_type   wr_word;
  logic            wr_ok;
  logic            ctrl_wr;
  owod_layout_type wr_layout;
  owod_layout_type load_layout;
  logic            load_ok;
  logic            next_erase;

  // Decodes a size and partition pair into a layout.
  function automatic owod_layout_type decode(input logic [3:0] sz,
                                             input logic [3:0] pt);
    owod_layout_type l;
    l = '0;
    l.valid = 1'b1;
    case (sz)
      `OWOD_SIZE_2K:   l.size_bytes = 13'h0800;
      `OWOD_SIZE_ZERO: l.size_bytes = 13'h0000;
      default:         l.valid = 1'b0;
    endcase
    case (pt)
      `OWOD_PART_32_0: begin
        l.data_kb   = 6'h20;
        l.backup_kb = 6'h00;
      end
      `OWOD_PART_8_24: begin
        l.data_kb   = 6'h08;
        l.backup_kb = 6'h18;
      end
      `OWOD_PART_0_32: begin
        l.data_kb   = 6'h00;
        l.backup_kb = 6'h20;
      end
      `OWOD_PART_16_16: begin
        l.data_kb   = 6'h10;
        l.backup_kb = 6'h10;
      end
      `OWOD_PART_24_8: begin
        l.data_kb   = 6'h18;
        l.backup_kb = 6'h08;
      end
      default: begin
        l.valid = 1'b0;
      end
    endcase
    // Zero size pairs only with zero backup, nonzero with nonzero.
    if ((sz == `OWOD_SIZE_ZERO) != (l.backup_kb == 6'h00)) begin
      l.valid = 1'b0;
    end
    return l;
  endfunction

  assign locked  = (store[`OWOD_LOCK_MSB:`OWOD_LOCK_LSB]
                    == `OWOD_LOCK_CODE);
  assign wr_word = owod_word_type'(wdata_in);
  assign ctrl_wr = wr_in && (addr_in == `OWOD_OFS_CTRL);
  // A low-half write that changes size or partition must be a legal layout.
  assign wr_layout = decode(wr_word.size, wr_word.part);
  assign wr_ok     = !locked && ((wr_word.size == store[11:8]
                      && wr_word.part == store[7:4])
                      || wr_layout.valid);

  // Reload decode of the stored entry; the boot load never asks for erase.
  assign load_ok     = (store[63:32] == ~store[31:0]);
  assign load_layout = decode(store[11:8], store[7:4]);
  assign next_erase  = load_ok && load_layout.valid && !boot_load
                       && (store[11:4] != {active.size, active.part});

  // Stored option entry; the high half is written with no legality check.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      store <= `OWOD_STORE_RESET;
    end else if (clk_en_in && wr_in && !locked) begin
      if (addr_in == `OWOD_OFS_STORE_LO && wr_ok) begin
        store[31:0] <= wdata_in;
      end else if (addr_in == `OWOD_OFS_STORE_HI) begin
        store[63:32] <= wdata_in;
      end
    end
  end

  // Illegal write attempt flag; sets on a refused pair, cleared by reload.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      illegal <= 1'b0;
    end else if (clk_en_in) begin
      if (wr_in && addr_in == `OWOD_OFS_STORE_LO && !locked && !wr_ok) begin
        illegal <= 1'b1;
      end else if (ctrl_wr && wdata_in[`OWOD_CTRL_RELOAD]) begin
        illegal <= 1'b0;
      end
    end
  end

  // One load runs automatically after reset; the flag stays up through it.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      boot_load <= 1'b1;
    end else if (clk_en_in && state == OWOD_RELOAD) begin
      boot_load <= 1'b0;
    end
  end

  // Loader sequence: apply the stored word, then hold for erase if size or partition changed.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state <= OWOD_IDLE;
    end else if (clk_en_in) begin
      case (state)
        OWOD_IDLE: begin
          if (boot_load || (ctrl_wr && wdata_in[`OWOD_CTRL_RELOAD])) begin
            state <= OWOD_RELOAD;
          end
        end
        OWOD_RELOAD: begin
          state <= next_erase ? OWOD_ERASE : OWOD_IDLE;
        end
        OWOD_ERASE: begin
          if (ctrl_wr && wdata_in[`OWOD_CTRL_ERASE_ACK]) begin
            state <= OWOD_IDLE;
          end
        end
        default: state <= OWOD_IDLE;
      endcase
    end
  end

  // Applies the word on reload; complement mismatch sets the error.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      active     <= '1;
      layout     <= '0;
      err        <= 1'b0;
      erase_pend <= 1'b0;
    end else if (clk_en_in) begin
      if (state == OWOD_RELOAD) begin
        erase_pend <= next_erase;
        if (!load_ok) begin
          err <= 1'b1;
        end else begin
          err    <= 1'b0;
          active <= owod_word_type'(store[31:0]);
          if (load_layout.valid) begin
            layout <= load_layout;
          end
        end
      end else if (state == OWOD_ERASE && ctrl_wr
                   && wdata_in[`OWOD_CTRL_ERASE_ACK]) begin
        erase_pend <= 1'b0;
      end
    end
  end

  // Registered read data, one cycle after the read strobe.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_out <= '0;
    end else if (clk_en_in) begin
      rdata_out <= '0;
      if (rd_in) begin
        case (addr_in)
          `OWOD_OFS_STORE_LO: rdata_out <= store[31:0];
          `OWOD_OFS_STORE_HI: rdata_out <= store[63:32];
          `OWOD_OFS_STATUS: rdata_out <= {27'h0, active.preload,
                                          erase_pend, illegal, locked, err};
          `OWOD_OFS_ACTIVE: rdata_out <= active;
          default:          rdata_out <= '0;
        endcase
      end
    end
  end

  assign preload_out   = active.preload;
  assign layout_out    = layout;
  assign erase_req_out = (state == OWOD_ERASE);
  assign error_out     = err | illegal;

  // Checks on write refusal, the loader and the erase request.
  AST_LOCK_HOLDS: assert property (@(posedge clk_in)
    disable iff (!arst_n_in)
    locked |=> $stable(store))
    else $error("Locked word changed.");
  AST_RELOAD_ERR: assert property (@(posedge clk_in)
    disable iff (!arst_n_in)
    (clk_en_in && state == OWOD_RELOAD && store[63:32] != ~store[31:0])
    |=> err)
    else $error("Complement mismatch not flagged.");
  AST_LAYOUT_OK: assert property (@(posedge clk_in)
    disable iff (!arst_n_in)
    layout.valid || layout == '0)
    else $error("Bad layout active.");
  AST_ACTIVE_RELOAD: assert property (@(posedge clk_in)
    disable iff (!arst_n_in)
    (state != OWOD_RELOAD) |=> $stable(active))
    else $error("Word applied outside reload.");
  AST_PRELOAD: assert property (@(posedge clk_in)
    disable iff (!arst_n_in)
    (clk_en_in && state == OWOD_RELOAD && store[63:32] == ~store[31:0])
    |=> preload_out == $past(store[`OWOD_PRELOAD_BIT]))
    else $error("Preload bit not applied.");
  AST_ILLEGAL: assert property (@(posedge clk_in)
    disable iff (!arst_n_in)
    (clk_en_in && wr_in && addr_in == `OWOD_OFS_STORE_LO && !locked
     && !wr_ok) |=> illegal && $stable(store[31:0]))
    else $error("Illegal write not refused.");
  AST_ERASE: assert property (@(posedge clk_in)
    disable iff (!arst_n_in)
    erase_req_out |-> erase_pend)
    else $error("Erase without change.");
  AST_UNLOCKED_WR: assert property (@(posedge clk_in)
    disable iff (!arst_n_in)
    (clk_en_in && wr_in && addr_in == `OWOD_OFS_STORE_HI && !locked)
    |=> store[63:32] == $past(wdata_in))
    else $error("Unlocked write lost.");
endmodule
`default_nettype wire

// File: verif/test_option_word_one_decoder.sv
`default_nettype none
module test_option_word_one_decoder
  import owod_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic            clk_in;
  logic            arst_n_in;
  logic            clk_en_in;
  logic [3:0]      addr_in;
  logic [31:0]     wdata_in;
  logic            wr_in;
  logic            rd_in;
  logic [31:0]     rdata_out;
  logic            preload_out;
  owod_layout_type layout_out;
  logic            erase_req_out;
  logic            error_out;
  int              errors;
  int              samples_checked;
  logic [31:0]     rv;
  logic [31:0]     cur;

  owod_decoder dut (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .clk_en_in(clk_en_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .preload_out(preload_out), .layout_out(layout_out),
    .erase_req_out(erase_req_out), .error_out(error_out));

  // The clock toggles every 2.5 ns, a period of 5 ns.
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  // Compares one value and counts the outcome.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One write cycle on the register port.
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clk_in);
    wr_in    <= 1'b0;
  endtask

  // One read cycle; the data are taken in the cycle after the strobe.
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_in);
    rd_in   <= 1'b0;
    #1 d = rdata_out;
  endtask

  // Writes the complement half first, since a locking low half blocks it.
  task automatic store(input logic [31:0] lo);
    wr(4'h1, ~lo);
    wr(4'h0, lo);
  endtask

  // Requests a reload and lets it land.
  task automatic reload();
    wr(4'h2, 32'h0000_0001);
    repeat (3) @(posedge clk_in);
    #1;
  endtask

  // Builds an option word from its fields.
  function automatic logic [31:0] mk(input logic [15:0] lk, input logic p,
                                     input logic [3:0] s, input logic [3:0] t);
    return {lk, p, 3'h0, s, t, 4'h0};
  endfunction

  // Builds the expected valid layout, zero extended to 32 bits.
  function automatic logic [31:0] lay(input logic [12:0] sb,
                                      input logic [5:0] dk,
                                      input logic [5:0] bk);
    return {6'h00, sb, dk, bk, 1'b1};
  endfunction

  // Boot load of the erased entry leaves no valid layout and no erase.
  task automatic t_boot();
    repeat (4) @(posedge clk_in);
    #1;
    chk(32'(layout_out), 32'h0);
    chk(32'(erase_req_out), 32'h0);
    chk(32'(error_out), 32'h0);
    chk(32'(preload_out), 32'h0);
  endtask

  // Every listed partition code, with a matching legal size.
  task automatic t_parts();
    logic [3:0]  pc [5] = '{4'h6, 4'h1, 4'h9, 4'hb, 4'hc};
    logic [3:0]  sc [5] = '{4'h4, 4'hf, 4'h4, 4'h4, 4'h4};
    logic [5:0]  dk [5] = '{6'h08, 6'h20, 6'h00, 6'h10, 6'h18};
    logic [5:0]  bk [5] = '{6'h18, 6'h00, 6'h20, 6'h10, 6'h08};
    logic [31:0] prev;
    prev = 32'h0;
    for (int i = 0; i < 5; i++) begin
      cur = mk(16'h0000, i[0], sc[i], pc[i]);
      store(cur);
      rd(4'h0, rv);
      chk(rv, cur);
      chk(32'(layout_out), prev);
      reload();
      prev = lay((sc[i] == 4'h4) ? 13'h0800 : 13'h0000, dk[i], bk[i]);
      chk(32'(layout_out), prev);
      chk(32'(preload_out), 32'(i[0]));
      chk(32'(erase_req_out), 32'h1);
      rd(4'h4, rv);
      chk(rv, cur);
      wr(4'h2, 32'h0000_0002);
      @(posedge clk_in);
      #1 chk(32'(erase_req_out), 32'h0);
    end
  endtask

  // Illegal size and partition pairs are dropped and flagged.
  task automatic t_illegal();
    wr(4'h0, mk(16'h0000, 1'b0, 4'hf, 4'h9));
    rd(4'h0, rv);
    chk(rv, cur);
    rd(4'h3, rv);
    chk(32'(rv[2]), 32'h1);
    chk(32'(error_out), 32'h1);
    wr(4'h0, mk(16'h0000, 1'b0, 4'h2, 4'h6));
    rd(4'h0, rv);
    chk(rv, cur);
    reload();
    chk(32'(error_out), 32'h0);
    chk(32'(erase_req_out), 32'h0);
    chk(32'(layout_out), lay(13'h0800, 6'h18, 6'h08));
  endtask

  // A stale complement half is caught on reload.
  task automatic t_mismatch();
    cur = mk(16'h0000, 1'b0, 4'h4, 4'hb);
    wr(4'h0, cur);
    reload();
    chk(32'(error_out), 32'h1);
    chk(32'(layout_out), lay(13'h0800, 6'h18, 6'h08));
    wr(4'h1, ~cur);
    reload();
    chk(32'(error_out), 32'h0);
    chk(32'(layout_out), lay(13'h0800, 6'h10, 6'h10));
    chk(32'(erase_req_out), 32'h1);
    wr(4'h2, 32'h0000_0002);
  endtask

  // A write while the clock enable is low leaves the entry untouched.
  task automatic t_freeze();
    @(posedge clk_in);
    clk_en_in <= 1'b0;
    wr(4'h0, mk(16'h0000, 1'b1, 4'h4, 4'hb));
    @(posedge clk_in);
    clk_en_in <= 1'b1;
    rd(4'h0, rv);
    chk(rv, cur);
  endtask

  // The lock code freezes both halves of the entry.
  task automatic t_lock();
    cur = mk(16'h33cc, 1'b1, 4'h4, 4'h6);
    store(cur);
    wr(4'h0, mk(16'h0000, 1'b0, 4'h4, 4'h9));
    wr(4'h1, 32'h0000_0000);
    rd(4'h0, rv);
    chk(rv, cur);
    rd(4'h1, rv);
    chk(rv, ~cur);
    rd(4'h3, rv);
    chk(32'(rv[1]), 32'h1);
    rd(4'hf, rv);
    chk(rv, 32'h0);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (5000) @(posedge clk_in);
    errors++;
    print_verdict();
  end

  // Main sequence: reset, then each scenario in turn.
  initial begin
    errors = 0;
    samples_checked = 0;
    arst_n_in = 1'b0;
    clk_en_in = 1'b1;
    addr_in = 4'h0;
    wdata_in = 32'h0;
    wr_in = 1'b0;
    rd_in = 1'b0;
    repeat (16) @(posedge clk_in);
    arst_n_in <= 1'b1;
    t_boot();
    t_parts();
    t_illegal();
    t_mismatch();
    t_freeze();
    t_lock();
    print_verdict();
  end
endmodule
`default_nettype wire
